// ==== rtl/tsr_conv_timer.v ====
`timescale 1ns/1ps
`include "tsr_defines.vh"

module tsr_conv_timer #(
  parameter [31:0] BASE_CYC = `TSR_CONV_BASE_CYC
) (
  input  wire       clk,
  input  wire       arst_n,
  input  wire       clk_en,
  input  wire       run,
  input  wire       restart,
  input  wire [2:0] rate,
  output reg        done
);

  reg  [31:0] cnt_q;
  wire [2:0]  shamt;
  wire [31:0] limit;

  // ----------------------------------------------------------------
  // Period per rate code
  // ----------------------------------------------------------------
  // Undefined codes above the table clamp to the slowest rate
  assign shamt = (rate > `TSR_RATE_MAX) ? `TSR_RATE_MAX : rate;
  assign limit = BASE_CYC << shamt;

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q <= 32'h0;
      done  <= 1'b0;
    end
    else if (clk_en)
    begin
      done <= 1'b0;
      if (restart || !run)
        cnt_q <= 32'h0;
      else if (cnt_q >= limit - 32'h1)
      begin
        cnt_q <= 32'h0;
        done  <= 1'b1;
      end
      else
        cnt_q <= cnt_q + 32'h1;
    end
  end

endmodule

// ==== rtl/tsr_defines.vh ====
`ifndef TSR_DEFINES_VH
`define TSR_DEFINES_VH

// ----------------------------------------------------------------
// Register pointers
// ----------------------------------------------------------------
`define TSR_PTR_VOLT      8'h00
`define TSR_PTR_TEMP      8'h01
`define TSR_PTR_CFG       8'h02
`define TSR_PTR_MAKER     8'hfe
`define TSR_PTR_PART      8'hff
`define TSR_PTR_RESET     8'h00

// ----------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------
`define TSR_CFG_RST       15
`define TSR_CFG_MODE_HI   14
`define TSR_CFG_MODE_LO   12
`define TSR_CFG_RATE_HI   11
`define TSR_CFG_RATE_LO   9
`define TSR_CFG_EN        8
`define TSR_CFG_RDY       7
`define TSR_CFG_RESET     16'h7400
`define TSR_MODE_OFF      3'h0
`define TSR_MODE_CONT     3'h7
`define TSR_RATE_MAX      3'h4

// ----------------------------------------------------------------
// Target address and identity (identity values arbitrary)
// ----------------------------------------------------------------
`define TSR_ADDR_UPPER    4'h8
`define TSR_MAKER_ID      16'h1a2b
`define TSR_PART_ID       16'h0c3d

// ----------------------------------------------------------------
// Sensor data
// ----------------------------------------------------------------
`define TSR_RAW_W         18
`define TSR_VOLT_POS_FS   16'h7fff
`define TSR_VOLT_NEG_FS   16'h8000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TSR_CLK_KHZ       100000
`define TSR_CONV_BASE_MS  250
`define TSR_CONV_BASE_CYC (`TSR_CONV_BASE_MS * `TSR_CLK_KHZ)

`endif

// ==== rtl/tsr_serial_regs.v ====
`timescale 1ns/1ps
`include "tsr_defines.vh"

module tsr_serial_regs #(
  parameter [31:0] CONV_BASE_CYC = `TSR_CONV_BASE_CYC
) (
  input  wire                  clk,
  input  wire                  arst_n,
  input  wire                  clk_en,
  input  wire                  scl_in,
  input  wire                  sda_in,
  output reg                   sda_out,
  output reg                   sda_oe,
  input  wire                  addr_strap_low,
  input  wire                  addr_strap_high,
  input  wire [`TSR_RAW_W-1:0] thermopile_voltage,
  input  wire [13:0]           die_temperature,
  output reg                   result_ready_n,
  output reg                   result_ready_oe,
  output reg                   conv_run
);

  // ----------------------------------------------------------------
  // Bus states
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_AACK  = 3'h2;
  localparam [2:0] ST_WBYTE = 3'h3;
  localparam [2:0] ST_WACK  = 3'h4;
  localparam [2:0] ST_RBYTE = 3'h5;
  localparam [2:0] ST_RACK  = 3'h6;
  localparam [15:0] CFG_INIT = `TSR_CFG_RESET;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  wire [3:0]  sync_q;
  wire        scl_s;
  wire        sda_s;
  wire        strap_lo_s;
  wire        strap_hi_s;
  reg         scl_prev_q;
  reg         sda_prev_q;
  reg         strap_lo_prev_q;
  wire        scl_rise;
  wire        scl_fall;
  wire        start_det;
  wire        stop_det;
  reg  [2:0]  state_q;
  reg  [3:0]  bit_cnt_q;
  reg  [7:0]  rx_sh_q;
  reg  [7:0]  tx_sh_q;
  reg  [7:0]  lo_byte_q;
  reg  [7:0]  hi_byte_q;
  reg  [1:0]  wr_idx_q;
  reg         rd_lo_next_q;
  reg         rw_q;
  reg         strap_idle_q;
  reg         strap_start_q;
  reg         strap_fall_q;
  reg         strap_hi_q;
  reg         first_fall_q;
  reg  [7:0]  ptr_q;
  reg  [2:0]  mode_q;
  reg  [2:0]  rate_q;
  reg         pin_en_q;
  reg         ready_q;
  reg  [15:0] volt_q;
  reg  [13:0] temp_q;
  reg         soft_rst_q;
  wire        conv_done;
  wire [15:0] rd_word;
  wire [6:0]  own_addr;
  reg         cfg_wr;
  reg         res_rd;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [1:0] strap_code;
    input idle_lvl;
    input start_lvl;
    input fall_lvl;
    begin
      if (!idle_lvl)
        strap_code = 2'h0;
      else if (!start_lvl)
        strap_code = 2'h2;
      else if (!fall_lvl)
        strap_code = 2'h3;
      else
        strap_code = 2'h1;
    end
  endfunction

  function [15:0] sat_volt;
    input [`TSR_RAW_W-1:0] raw;
    begin
      if (raw[`TSR_RAW_W-1:15] == {(`TSR_RAW_W-15){raw[15]}})
        sat_volt = raw[15:0];
      else if (raw[`TSR_RAW_W-1])
        sat_volt = `TSR_VOLT_NEG_FS;
      else
        sat_volt = `TSR_VOLT_POS_FS;
    end
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers and edge detection
  // ----------------------------------------------------------------
  tsr_sync #(
    .W      (4)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .clk_en (clk_en),
    .d      ({addr_strap_high, addr_strap_low, sda_in, scl_in}),
    .q      (sync_q)
  );

  assign scl_s      = sync_q[0];
  assign sda_s      = sync_q[1];
  assign strap_lo_s = sync_q[2];
  assign strap_hi_s = sync_q[3];

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_prev_q      <= 1'b1;
      sda_prev_q      <= 1'b1;
      strap_lo_prev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      scl_prev_q      <= scl_s;
      sda_prev_q      <= sda_s;
      strap_lo_prev_q <= strap_lo_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_prev_q;
  assign scl_fall  = ~scl_s & scl_prev_q;
  assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // A strap tied to a bus line is told apart by three samples:
  // idle before start, just after start, first clock low.
  assign own_addr = {`TSR_ADDR_UPPER, strap_hi_q,
                     strap_code(strap_idle_q, strap_start_q, strap_fall_q)};

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  assign rd_word = (ptr_q == `TSR_PTR_VOLT)  ? volt_q :
                   (ptr_q == `TSR_PTR_TEMP)  ? {temp_q, 2'b00} :
                   (ptr_q == `TSR_PTR_CFG)   ? {1'b0, mode_q, rate_q, pin_en_q,
                                                ready_q, 7'h00} :
                   (ptr_q == `TSR_PTR_MAKER) ? `TSR_MAKER_ID :
                   (ptr_q == `TSR_PTR_PART)  ? `TSR_PART_ID : 16'h0000;

  // ----------------------------------------------------------------
  // Bus engine
  // ----------------------------------------------------------------
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q       <= ST_IDLE;
      bit_cnt_q     <= 4'h0;
      rx_sh_q       <= 8'h00;
      tx_sh_q       <= 8'h00;
      lo_byte_q     <= 8'h00;
      hi_byte_q     <= 8'h00;
      wr_idx_q      <= 2'h0;
      rd_lo_next_q  <= 1'b0;
      rw_q          <= 1'b0;
      strap_idle_q  <= 1'b0;
      strap_start_q <= 1'b0;
      strap_fall_q  <= 1'b0;
      strap_hi_q    <= 1'b0;
      first_fall_q  <= 1'b0;
      ptr_q         <= `TSR_PTR_RESET;
      sda_oe        <= 1'b0;
      sda_out       <= 1'b0;
      cfg_wr        <= 1'b0;
      res_rd        <= 1'b0;
    end
    else if (clk_en)
    begin
      cfg_wr <= 1'b0;
      res_rd <= 1'b0;
      if (soft_rst_q)
        ptr_q <= `TSR_PTR_RESET;
      if (start_det)
      begin
        state_q       <= ST_ADDR;
        bit_cnt_q     <= 4'h0;
        sda_oe        <= 1'b0;
        strap_idle_q  <= strap_lo_prev_q;
        strap_start_q <= strap_lo_s;
        strap_hi_q    <= strap_hi_s;
        first_fall_q  <= 1'b1;
      end
      else if (stop_det)
      begin
        state_q <= ST_IDLE;
        sda_oe  <= 1'b0;
      end
      else
      begin
        if (scl_fall && first_fall_q)
        begin
          strap_fall_q <= strap_lo_s;
          first_fall_q <= 1'b0;
        end
        if (scl_rise)
        begin
          if (state_q == ST_ADDR || state_q == ST_WBYTE)
          begin
            rx_sh_q   <= {rx_sh_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          else if (state_q == ST_RACK && sda_s)
            state_q <= ST_IDLE;
        end
        if (scl_fall)
        begin
          case (state_q)
            ST_ADDR:
            begin
              if (bit_cnt_q == 4'h8)
              begin
                if (rx_sh_q[7:1] == own_addr)
                begin
                  rw_q    <= rx_sh_q[0];
                  sda_oe  <= 1'b1;
                  state_q <= ST_AACK;
                end
                else
                  state_q <= ST_IDLE;
              end
            end
            ST_AACK:
            begin
              bit_cnt_q <= 4'h0;
              wr_idx_q  <= 2'h0;
              if (rw_q)
              begin
                tx_sh_q      <= rd_word[15:8];
                lo_byte_q    <= rd_word[7:0];
                rd_lo_next_q <= 1'b1;
                sda_oe       <= ~rd_word[15];
                res_rd       <= (ptr_q == `TSR_PTR_VOLT) ||
                                (ptr_q == `TSR_PTR_TEMP);
                state_q      <= ST_RBYTE;
              end
              else
              begin
                sda_oe  <= 1'b0;
                state_q <= ST_WBYTE;
              end
            end
            ST_WBYTE:
            begin
              if (bit_cnt_q == 4'h8)
              begin
                if (wr_idx_q == 2'h0)
                  ptr_q <= rx_sh_q;
                else if (wr_idx_q == 2'h1)
                  hi_byte_q <= rx_sh_q;
                else if (wr_idx_q == 2'h2 && ptr_q == `TSR_PTR_CFG)
                  cfg_wr <= 1'b1;
                if (wr_idx_q != 2'h3)
                  wr_idx_q <= wr_idx_q + 2'h1;
                sda_oe  <= 1'b1;
                state_q <= ST_WACK;
              end
            end
            ST_WACK:
            begin
              sda_oe    <= 1'b0;
              bit_cnt_q <= 4'h0;
              state_q   <= ST_WBYTE;
            end
            ST_RBYTE:
            begin
              if (bit_cnt_q == 4'h7)
              begin
                sda_oe  <= 1'b0;
                state_q <= ST_RACK;
              end
              else
              begin
                tx_sh_q   <= {tx_sh_q[6:0], 1'b0};
                sda_oe    <= ~tx_sh_q[6];
                bit_cnt_q <= bit_cnt_q + 4'h1;
              end
            end
            ST_RACK:
            begin
              // Controller acked: continue, high byte again after low
              bit_cnt_q    <= 4'h0;
              tx_sh_q      <= rd_lo_next_q ? lo_byte_q : rd_word[15:8];
              sda_oe       <= rd_lo_next_q ? ~lo_byte_q[7] : ~rd_word[15];
              if (!rd_lo_next_q)
                lo_byte_q <= rd_word[7:0];
              rd_lo_next_q <= ~rd_lo_next_q;
              state_q      <= ST_RBYTE;
            end
            default:
              state_q <= ST_IDLE;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration, results and ready flag
  // ----------------------------------------------------------------
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_q     <= CFG_INIT[`TSR_CFG_MODE_HI:`TSR_CFG_MODE_LO];
      rate_q     <= CFG_INIT[`TSR_CFG_RATE_HI:`TSR_CFG_RATE_LO];
      pin_en_q   <= 1'b0;
      ready_q    <= 1'b0;
      volt_q     <= 16'h0000;
      temp_q     <= 14'h0000;
      soft_rst_q <= 1'b0;
    end
    else if (clk_en)
    begin
      soft_rst_q <= 1'b0;
      if (soft_rst_q)
      begin
        // Soft reset returns every register to its reset value
        mode_q   <= CFG_INIT[`TSR_CFG_MODE_HI:`TSR_CFG_MODE_LO];
        rate_q   <= CFG_INIT[`TSR_CFG_RATE_HI:`TSR_CFG_RATE_LO];
        pin_en_q <= 1'b0;
        ready_q  <= 1'b0;
        volt_q   <= 16'h0000;
        temp_q   <= 14'h0000;
      end
      else
      begin
        if (cfg_wr)
        begin
          soft_rst_q <= hi_byte_q[`TSR_CFG_RST-8];
          mode_q     <= hi_byte_q[`TSR_CFG_MODE_HI-8:`TSR_CFG_MODE_LO-8];
          rate_q     <= hi_byte_q[`TSR_CFG_RATE_HI-8:`TSR_CFG_RATE_LO-8];
          pin_en_q   <= hi_byte_q[`TSR_CFG_EN-8];
        end
        if (conv_done)
        begin
          volt_q  <= sat_volt(thermopile_voltage);
          temp_q  <= die_temperature;
          ready_q <= 1'b1;
        end
        else if (cfg_wr || res_rd)
          ready_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Conversion pacing
  // ----------------------------------------------------------------
  // Power-down aborts the running conversion immediately
  tsr_conv_timer #(
    .BASE_CYC (CONV_BASE_CYC)
  ) u_timer (
    .clk      (clk),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .run      (mode_q != `TSR_MODE_OFF),
    .restart  (soft_rst_q | cfg_wr),
    .rate     (rate_q),
    .done     (conv_done)
  );

  // ----------------------------------------------------------------
  // Ready pin, open drain
  // ----------------------------------------------------------------
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      result_ready_n  <= 1'b0;
      result_ready_oe <= 1'b0;
      conv_run        <= 1'b0;
    end
    else if (clk_en)
    begin
      result_ready_n  <= 1'b0;
      result_ready_oe <= pin_en_q & ready_q;
      conv_run        <= (mode_q != `TSR_MODE_OFF);
    end
  end

endmodule

// ==== rtl/tsr_sync.v ====
`timescale 1ns/1ps
`include "tsr_defines.vh"

module tsr_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         arst_n,
  input  wire         clk_en,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  genvar i;

  // ----------------------------------------------------------------
  // Two flops per bit
  // ----------------------------------------------------------------
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      reg meta_q;
      reg sync_q;
      always @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
        end
        else if (clk_en)
        begin
          meta_q <= d[i];
          sync_q <= meta_q;
        end
      end
      assign q[i] = sync_q;
    end
  endgenerate

endmodule

// ==== test/tsr_bus_ctl.sv ====
`timescale 1ns/1ps

module tsr_bus_ctl (
  input  wire clk,
  input  wire sda,
  output reg  scl,
  output reg  sda_low
);
  // ----------------------------------------------------------------
  // Bus controller model, open-drain on the data line, clock driven directly
  // ----------------------------------------------------------------
  // Bus clock phase in system cycles; the design wants at least 8
  localparam int HALF = 8;

  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic gap();
    repeat (HALF) @(negedge clk);
  endtask

  // Clock stands still high between frames
  task automatic start_cond();
    sda_low = 1'b0;
    gap();
    scl = 1'b1;
    gap();
    sda_low = 1'b1;
    gap();
    scl = 1'b0;
  endtask

  task automatic stop_cond();
    sda_low = 1'b1;
    gap();
    scl = 1'b1;
    gap();
    sda_low = 1'b0;
    gap();
  endtask

  // Data moves one cycle after the clock fall, so no edge looks like a start
  task automatic put_bit(input logic b, output logic r);
    @(negedge clk);
    sda_low = ~b;
    gap();
    scl = 1'b1;
    gap();
    r = sda;
    scl = 1'b0;
  endtask

  // Eight bits most significant first, then the acknowledge slot
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
      put_bit(tx[i], rx[i]);
  endtask
endmodule

// ==== test/tsr_serial_regs_sva.sv ====
`timescale 1ns/1ps
`include "tsr_defines.vh"

module tsr_serial_regs_sva #(
  parameter [31:0] CONV_BASE_CYC = `TSR_CONV_BASE_CYC
) (
  input wire                  clk,
  input wire                  arst_n,
  input wire                  clk_en,
  input wire                  scl_in,
  input wire                  sda_in,
  input wire                  sda_out,
  input wire                  sda_oe,
  input wire                  addr_strap_low,
  input wire                  addr_strap_high,
  input wire [`TSR_RAW_W-1:0] thermopile_voltage,
  input wire [13:0]           die_temperature,
  input wire                  result_ready_n,
  input wire                  result_ready_oe,
  input wire                  conv_run
);
  // ----------------------------------------------------------------
  // Pin behaviour
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_ready_pull_only: assert property (result_ready_n == 1'b0)
    else $error("ready pin driven high");
  a_sda_pull_only: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_reset_quiet: assert property ($rose(arst_n) |-> !sda_oe && !result_ready_oe && !conv_run)
    else $error("outputs active right after reset");
  a_conv_autostart: assert property ($rose(arst_n) |-> ##[1:2] conv_run)
    else $error("conversions not started after reset");
  // Drive may only start a few cycles after the bus clock fell
  a_drive_after_fall: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in, 2) &&
    ($past(scl_in, 3) || $past(scl_in, 4) || $past(scl_in, 5) || $past(scl_in, 6)))
    else $error("data pull not launched by clock fall");
  a_drive_holds: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("data pull released too soon");
  a_ready_clear_low: assert property ($fell(result_ready_oe) |-> !scl_in)
    else $error("ready cleared outside a bus access");
  a_ready_needs_run: assert property ($rose(result_ready_oe) |-> $past(conv_run))
    else $error("ready raised while powered down");

  cover property ($rose(sda_oe));
  cover property ($rose(result_ready_oe));
  cover property ($fell(conv_run));
endmodule

bind tsr_serial_regs tsr_serial_regs_sva #(.CONV_BASE_CYC(CONV_BASE_CYC)) chk_u (
  .clk(clk), .arst_n(arst_n), .clk_en(clk_en), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_low(addr_strap_low),
  .addr_strap_high(addr_strap_high), .thermopile_voltage(thermopile_voltage),
  .die_temperature(die_temperature), .result_ready_n(result_ready_n),
  .result_ready_oe(result_ready_oe), .conv_run(conv_run)
);

// ==== test/tsr_serial_regs_test.sv ====
`timescale 1ns/1ps
`include "tsr_defines.vh"

module tsr_serial_regs_test;
  // ----------------------------------------------------------------
  // Bench signals
  // ----------------------------------------------------------------
  // Short base period keeps the 4 s rate at 3200 cycles
  localparam logic [31:0] BASE = 32'd200;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        a_hi = 1'b0;
  logic [1:0]  lo_sel = 2'h0;
  logic [17:0] volt_in = 18'h00123;
  logic [13:0] temp_in = 14'h0000;
  wire         sda_oe, rdy_oe, conv_run, scl_w, ctl_low;
  wire         sda_w = ~(sda_oe | ctl_low);
  wire         strap_lo = (lo_sel == 2'h0) ? 1'b0 : (lo_sel == 2'h1) ? 1'b1 :
                          (lo_sel == 2'h2) ? sda_w : scl_w;
  int          fails = 0;
  int          n_checks = 0;
  logic [6:0]  dev;
  logic [15:0] v;
  logic        ack;
  logic [17:0] vin [4] = '{18'h1ffff, 18'h20000, 18'h00001, 18'h3ffff};
  logic [15:0] vexp [4] = '{16'h7fff, 16'h8000, 16'h0001, 16'hffff};

  always #5 clk = ~clk;

  tsr_serial_regs #(.CONV_BASE_CYC(BASE)) dut_u (
    .clk(clk), .arst_n(arst_n), .clk_en(1'b1), .scl_in(scl_w), .sda_in(sda_w),
    .sda_out(), .sda_oe(sda_oe), .addr_strap_low(strap_lo), .addr_strap_high(a_hi),
    .thermopile_voltage(volt_in), .die_temperature(temp_in), .result_ready_n(),
    .result_ready_oe(rdy_oe), .conv_run(conv_run)
  );

  tsr_bus_ctl ctl_u (.clk(clk), .sda(sda_w), .scl(scl_w), .sda_low(ctl_low));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Pointer byte, then the word when with_data is set
  task automatic wr(input logic [6:0] a, input logic [7:0] ptr, input logic [15:0] d,
                    input logic with_data, output logic ok);
    logic [8:0] r0, r1, r2, r3;
    r2 = 9'h0;
    r3 = 9'h0;
    ctl_u.start_cond();
    ctl_u.xfer({a, 1'b0, 1'b1}, r0);
    ctl_u.xfer({ptr, 1'b1}, r1);
    if (with_data)
    begin
      ctl_u.xfer({d[15:8], 1'b1}, r2);
      ctl_u.xfer({d[7:0], 1'b1}, r3);
    end
    ctl_u.stop_cond();
    ok = ~(r0[0] | r1[0] | r2[0] | r3[0]);
  endtask

  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    logic [8:0] r0, r1, r2;
    ctl_u.start_cond();
    ctl_u.xfer({a, 1'b1, 1'b1}, r0);
    ctl_u.xfer(9'h1fe, r1);
    ctl_u.xfer(9'h1ff, r2);
    ctl_u.stop_cond();
    check("read address ack", 16'h0, {15'h0, r0[0]});
    d = {r1[8:1], r2[8:1]};
  endtask

  // One 4 s conversion is 3200 cycles
  task automatic wait_ready();
    for (int i = 0; i < 4000 && rdy_oe !== 1'b1; i++)
      @(negedge clk);
    check("ready pin", 16'h1, {15'h0, rdy_oe});
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    dev = {`TSR_ADDR_UPPER, 3'h0};
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
    rd(dev, v);
    check("voltage after reset", 16'h0000, v);
    check("running", 16'h1, {15'h0, conv_run});
    wr(dev, 8'h02, 16'h0, 1'b0, ack);
    rd(dev, v);
    check("config reset", 16'h7400, v & 16'hff7f);
    wr(dev, 8'hfe, 16'h5555, 1'b1, ack);
    rd(dev, v);
    check("maker id", 16'h1a2b, v);
    wr(dev, 8'hff, 16'h0, 1'b0, ack);
    rd(dev, v);
    check("part id", 16'h0c3d, v);
    wr(dev, 8'h03, 16'h0, 1'b0, ack);
    rd(dev, v);
    check("unused pointer", 16'h0000, v);
    wr(dev, 8'h02, 16'h7900, 1'b1, ack);
    rd(dev, v);
    check("config written", 16'h7900, v);
    wr(dev, 8'h00, 16'h0, 1'b0, ack);
    for (int k = 0; k < 4; k++)
    begin
      volt_in = vin[k];
      rd(dev, v);
      wait_ready();
      rd(dev, v);
      check("voltage", vexp[k], v);
      check("ready after read", 16'h0, {15'h0, rdy_oe});
    end
    temp_in = 14'h3001;
    wr(dev, 8'h01, 16'h0, 1'b0, ack);
    rd(dev, v);
    wait_ready();
    rd(dev, v);
    check("temperature", 16'hc004, v);
    wr(dev, 8'h02, 16'h0900, 1'b1, ack);
    repeat (4) @(negedge clk);
    check("powered down", 16'h0, {15'h0, conv_run});
    repeat (3400) @(negedge clk);
    check("no conversion", 16'h0, {15'h0, rdy_oe});
    wr(dev, 8'h02, 16'h8000, 1'b1, ack);
    rd(dev, v);
    check("voltage after soft reset", 16'h0000, v);
    check("running again", 16'h1, {15'h0, conv_run});
    // Default rate 010 is four base periods; pin enabled to see it
    wr(dev, 8'h02, 16'h7500, 1'b1, ack);
    repeat (4 * BASE - 100) @(negedge clk);
    check("ready too early", 16'h0, {15'h0, rdy_oe});
    repeat (150) @(negedge clk);
    check("ready at default rate", 16'h1, {15'h0, rdy_oe});
    for (int s = 0; s < 8; s++)
    begin
      a_hi = s[2];
      lo_sel = s[1:0];
      repeat (4) @(negedge clk);
      wr({`TSR_ADDR_UPPER, s[2:0]}, 8'h00, 16'h0, 1'b0, ack);
      check("own address ack", 16'h1, {15'h0, ack});
      wr({`TSR_ADDR_UPPER, s[2:0] ^ 3'h1}, 8'h00, 16'h0, 1'b0, ack);
      check("other address ack", 16'h0, {15'h0, ack});
    end
    conclude();
  end

  // Whole run takes about 35k cycles
  initial
  begin
    repeat (60000) @(posedge clk);
    fails++;
    conclude();
  end
endmodule
